//--- pkg/trab_pkg.sv
package trab_pkg;
   // widths of the serial-interface access port
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int TEST_ADDR_W = 8;

   // test register offsets
   localparam logic [7:0] OFS_TEST_PIN_ACTIVATE = 8'h03;
   localparam logic [7:0] OFS_COMM_TX_BUFFER = 8'h04;
   localparam logic [7:0] OFS_COMM_READY_FLAG = 8'h05;
   localparam logic [7:0] OFS_ANALOG_PROBE_OUT_SELECT = 8'h06;
   localparam logic [7:0] OFS_DIGITAL_PROBE_OUT_SELECT = 8'h07;
   localparam logic [7:0] OFS_ANALOG_PROBE_IN_SELECT = 8'h08;
   localparam logic [7:0] OFS_DIGITAL_PROBE_IN_SELECT = 8'h09;
   localparam logic [7:0] OFS_NONVOLATILE_BANK_ACCESS = 8'h0d;
   localparam logic [7:0] OFS_HOST_TAKEOVER_CONTROL = 8'h0e;
   localparam logic [7:0] OFS_SINGLE_WIRE_ERROR_LOW = 8'h14;
   localparam logic [7:0] OFS_SINGLE_WIRE_ERROR_HIGH = 8'h15;

   // implemented widths, bits above read as zero
   localparam int W_PIN_ACT = 4;
   localparam int W_COMM_BUF = 8;
   localparam int W_COMM_RDY = 1;
   localparam int W_AN_OUT_SEL = 6;
   localparam int W_DG_OUT_SEL = 5;
   localparam int W_AN_IN_SEL = 6;
   localparam int W_DG_IN_SEL = 4;
   localparam int W_NV_BANK = 6;
   localparam int W_TAKEOVER = 2;
   localparam int W_ERR_LOW = 8;
   localparam int W_ERR_HIGH = 2;

   // field positions
   localparam int BIT_PROBE_IN_P = 0;
   localparam int BIT_PROBE_OUT_N = 1;
   localparam int BIT_PROBE_OUT_P = 2;
   localparam int BIT_ERR_CLEAR = 3;
   localparam int BIT_COMM_VALID = 0;
   localparam int BIT_HOST_SELECT = 0;
   localparam int BIT_MCU_RESET = 1;

   // reset value of every test register and of a refused read
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // access sequencer states, gray coded
   typedef enum logic [1:0] {
      TRAB_IDLE = 2'b00,
      TRAB_MEM_WAIT = 2'b01
   } trab_state_t;
endpackage

//--- rtl/trab_flag_reg.sv
`timescale 1ns/1ps
// one test register: host write, hardware load, hardware set bits and clear
module trab_flag_reg #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   input wire logic ld_en,
   input wire logic [W-1:0] ld_data,
   input wire logic [W-1:0] set_bits,
   input wire logic clr,
   output logic [W-1:0] q
);
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // clear, then host write, then hardware load; set bits win over all
   always_comb begin
      q_next = q_reg;
      if (clr) begin
         q_next = '0;
      end
      if (wr_en) begin
         q_next = wr_data;
      end
      if (ld_en) begin
         q_next = ld_data;
      end
      q_next = q_next | set_bits;
   end

   // all bits zero at reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule

//--- rtl/trab_mem_arbiter.sv
`timescale 1ns/1ps
// memory ownership: serial host or microcontroller, never both
module trab_mem_arbiter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_select,
   input wire logic start,
   input wire logic start_wr,
   input wire logic [trab_pkg::ADDR_W-1:0] start_addr,
   input wire logic [trab_pkg::DATA_W-1:0] start_wdata,
   output logic mem_req,
   output logic mem_wr,
   output logic [trab_pkg::ADDR_W-1:0] mem_addr,
   output logic [trab_pkg::DATA_W-1:0] mem_wdata,
   output logic refused,
   output logic mcu_mem_enable
);
   logic req_reg, req_next;
   logic wr_reg, wr_next;
   logic [trab_pkg::ADDR_W-1:0] addr_reg, addr_next;
   logic [trab_pkg::DATA_W-1:0] wdata_reg, wdata_next;
   logic refused_reg, refused_next;
   logic mcu_en_reg, mcu_en_next;

   // forward a host access only while the host owns memory
   always_comb begin
      req_next = start & host_select;
      refused_next = start & ~host_select;
      wr_next = wr_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      if (start & host_select) begin
         wr_next = start_wr;
         addr_next = start_addr;
         wdata_next = start_wdata;
      end
      mcu_en_next = ~host_select;
   end

   // the microcontroller owns memory out of reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         refused_reg <= 1'b0;
         mcu_en_reg <= 1'b1;
      end else begin
         req_reg <= req_next;
         wr_reg <= wr_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         refused_reg <= refused_next;
         mcu_en_reg <= mcu_en_next;
      end
   end

   assign mem_req = req_reg;
   assign mem_wr = wr_reg;
   assign mem_addr = addr_reg;
   assign mem_wdata = wdata_reg;
   assign refused = refused_reg;
   assign mcu_mem_enable = mcu_en_reg;
endmodule

//--- rtl/trab_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - test registers are reached only through the serial host access port
// - no microcontroller bus port reaches the test registers
// - after power-up the serial host reaches only the test register space
// - host select set: host reaches all memory, microcontroller is blocked
// - while host owns memory, microcontroller loses all memory, program included
// - pin-activate bit 0 turns general pin 2 into positive test input
// - pin-activate bit 1 turns general pin 4 into negative test output
// - pin-activate bit 2 turns general pin 3 into positive test output
// - pin-activate bit 3 clears single-wire error bits, else they are kept until the host writes them
// - read/write byte buffer at test address 04, reset zero
// - ready bit 0 is set when the microcontroller loads its buffer
module trab_bank (
   input wire logic clk,
   input wire logic rst_n,
   // serial host access port, decoded by the spi, i2c or single-wire front end
   input wire logic sif_req,
   input wire logic sif_wr,
   input wire logic sif_test_space,
   input wire logic [trab_pkg::ADDR_W-1:0] sif_addr,
   input wire logic [trab_pkg::DATA_W-1:0] sif_wdata,
   output logic [trab_pkg::DATA_W-1:0] sif_rdata,
   output logic sif_ack,
   // memory port used when the host owns memory
   output logic mem_req,
   output logic mem_wr,
   output logic [trab_pkg::ADDR_W-1:0] mem_addr,
   output logic [trab_pkg::DATA_W-1:0] mem_wdata,
   input wire logic [trab_pkg::DATA_W-1:0] mem_rdata,
   input wire logic mem_ack,
   // microcontroller side
   output logic mcu_mem_enable,
   output logic mcu_reset_hold,
   input wire logic mcu_comm_load,
   input wire logic [trab_pkg::DATA_W-1:0] mcu_comm_byte,
   output logic [trab_pkg::DATA_W-1:0] comm_buffer_byte,
   output logic comm_data_valid,
   // single-wire link error events
   input wire logic [trab_pkg::W_ERR_LOW-1:0] single_wire_error_low_set,
   input wire logic [trab_pkg::W_ERR_HIGH-1:0] single_wire_error_high_set,
   output logic [trab_pkg::W_ERR_LOW-1:0] single_wire_error_low,
   output logic [trab_pkg::W_ERR_HIGH-1:0] single_wire_error_high,
   // test pin and probe controls
   output logic probe_in_p_enable,
   output logic probe_out_n_enable,
   output logic probe_out_p_enable,
   output logic [trab_pkg::W_AN_OUT_SEL-1:0] analog_probe_out_select,
   output logic [trab_pkg::W_DG_OUT_SEL-1:0] digital_probe_out_select,
   output logic [trab_pkg::W_AN_IN_SEL-1:0] analog_probe_in_select,
   output logic [trab_pkg::W_DG_IN_SEL-1:0] digital_probe_in_select,
   output logic [trab_pkg::W_NV_BANK-1:0] nonvolatile_bank_access
);
   trab_pkg::trab_state_t state_reg, state_next;
   logic ack_reg, ack_next;
   logic [trab_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic [trab_pkg::TEST_ADDR_W-1:0] taddr;
   logic test_wr;
   logic test_rd;
   logic mem_start;
   logic refused;
   logic [trab_pkg::DATA_W-1:0] test_rdata;

   logic [trab_pkg::W_PIN_ACT-1:0] pin_act_q;
   logic [trab_pkg::W_COMM_BUF-1:0] comm_buf_q;
   logic [trab_pkg::W_COMM_RDY-1:0] comm_rdy_q;
   logic [trab_pkg::W_AN_OUT_SEL-1:0] an_out_q;
   logic [trab_pkg::W_DG_OUT_SEL-1:0] dg_out_q;
   logic [trab_pkg::W_AN_IN_SEL-1:0] an_in_q;
   logic [trab_pkg::W_DG_IN_SEL-1:0] dg_in_q;
   logic [trab_pkg::W_NV_BANK-1:0] nv_q;
   logic [trab_pkg::W_TAKEOVER-1:0] takeover_q;
   logic [trab_pkg::W_ERR_LOW-1:0] err_low_q;
   logic [trab_pkg::W_ERR_HIGH-1:0] err_high_q;
   logic err_clear;

   // test space accesses come only from the serial port, taken in idle
   assign taddr = sif_addr[trab_pkg::TEST_ADDR_W-1:0];
   assign test_wr = (state_reg == trab_pkg::TRAB_IDLE) & sif_req & sif_test_space
      & sif_wr;
   assign test_rd = (state_reg == trab_pkg::TRAB_IDLE) & sif_req & sif_test_space & ~sif_wr;
   assign mem_start = (state_reg == trab_pkg::TRAB_IDLE) & sif_req & ~sif_test_space;
   assign err_clear = pin_act_q[trab_pkg::BIT_ERR_CLEAR];

   // test pin activation
   trab_flag_reg #(.W(trab_pkg::W_PIN_ACT)) u_pin_act (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_TEST_PIN_ACTIVATE),
      .wr_data(sif_wdata[trab_pkg::W_PIN_ACT-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(pin_act_q)
   );

   // communication buffer, host writable, loaded by the microcontroller
   trab_flag_reg #(.W(trab_pkg::W_COMM_BUF)) u_comm_buf (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_COMM_TX_BUFFER),
      .wr_data(sif_wdata),
      .ld_en(mcu_comm_load),
      .ld_data(mcu_comm_byte),
      .set_bits('0),
      .clr(1'b0),
      .q(comm_buf_q)
   );

   // buffer ready flag, set by a microcontroller load, set wins over a write
   trab_flag_reg #(.W(trab_pkg::W_COMM_RDY)) u_comm_rdy (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_COMM_READY_FLAG),
      .wr_data(sif_wdata[trab_pkg::W_COMM_RDY-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits(mcu_comm_load),
      .clr(1'b0),
      .q(comm_rdy_q)
   );

   // analog probe output selection
   trab_flag_reg #(.W(trab_pkg::W_AN_OUT_SEL)) u_an_out (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_ANALOG_PROBE_OUT_SELECT),
      .wr_data(sif_wdata[trab_pkg::W_AN_OUT_SEL-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(an_out_q)
   );

   // digital probe output selection
   trab_flag_reg #(.W(trab_pkg::W_DG_OUT_SEL)) u_dg_out (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_DIGITAL_PROBE_OUT_SELECT),
      .wr_data(sif_wdata[trab_pkg::W_DG_OUT_SEL-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(dg_out_q)
   );

   // analog probe input selection
   trab_flag_reg #(.W(trab_pkg::W_AN_IN_SEL)) u_an_in (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_ANALOG_PROBE_IN_SELECT),
      .wr_data(sif_wdata[trab_pkg::W_AN_IN_SEL-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(an_in_q)
   );

   // digital probe input selection
   trab_flag_reg #(.W(trab_pkg::W_DG_IN_SEL)) u_dg_in (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_DIGITAL_PROBE_IN_SELECT),
      .wr_data(sif_wdata[trab_pkg::W_DG_IN_SEL-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(dg_in_q)
   );

   // nonvolatile bank access bits, six wide, passed out as stored
   trab_flag_reg #(.W(trab_pkg::W_NV_BANK)) u_nv (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_NONVOLATILE_BANK_ACCESS),
      .wr_data(sif_wdata[trab_pkg::W_NV_BANK-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(nv_q)
   );

   // host takeover: memory ownership and microcontroller reset hold
   trab_flag_reg #(.W(trab_pkg::W_TAKEOVER)) u_takeover (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_HOST_TAKEOVER_CONTROL),
      .wr_data(sif_wdata[trab_pkg::W_TAKEOVER-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits('0),
      .clr(1'b0),
      .q(takeover_q)
   );

   // single-wire error bits, kept until cleared or written by the host; a new error wins over clear
   trab_flag_reg #(.W(trab_pkg::W_ERR_LOW)) u_err_low (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_SINGLE_WIRE_ERROR_LOW),
      .wr_data(sif_wdata[trab_pkg::W_ERR_LOW-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits(single_wire_error_low_set),
      .clr(err_clear),
      .q(err_low_q)
   );

   trab_flag_reg #(.W(trab_pkg::W_ERR_HIGH)) u_err_high (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(test_wr && taddr == trab_pkg::OFS_SINGLE_WIRE_ERROR_HIGH),
      .wr_data(sif_wdata[trab_pkg::W_ERR_HIGH-1:0]),
      .ld_en(1'b0),
      .ld_data('0),
      .set_bits(single_wire_error_high_set),
      .clr(err_clear),
      .q(err_high_q)
   );

   // memory ownership follows the host select bit
   trab_mem_arbiter u_arb (
      .clk(clk),
      .rst_n(rst_n),
      .host_select(takeover_q[trab_pkg::BIT_HOST_SELECT]),
      .start(mem_start),
      .start_wr(sif_wr),
      .start_addr(sif_addr),
      .start_wdata(sif_wdata),
      .mem_req(mem_req),
      .mem_wr(mem_wr),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .refused(refused),
      .mcu_mem_enable(mcu_mem_enable)
   );

   // test register read mux, unmapped offsets read zero
   always_comb begin
      test_rdata = trab_pkg::RESET_BYTE;
      case (taddr)
         trab_pkg::OFS_TEST_PIN_ACTIVATE: test_rdata[trab_pkg::W_PIN_ACT-1:0] = pin_act_q;
         trab_pkg::OFS_COMM_TX_BUFFER: test_rdata = comm_buf_q;
         trab_pkg::OFS_COMM_READY_FLAG: test_rdata[trab_pkg::W_COMM_RDY-1:0] = comm_rdy_q;
         trab_pkg::OFS_ANALOG_PROBE_OUT_SELECT: test_rdata[trab_pkg::W_AN_OUT_SEL-1:0] = an_out_q;
         trab_pkg::OFS_DIGITAL_PROBE_OUT_SELECT: test_rdata[trab_pkg::W_DG_OUT_SEL-1:0] = dg_out_q;
         trab_pkg::OFS_ANALOG_PROBE_IN_SELECT: test_rdata[trab_pkg::W_AN_IN_SEL-1:0] = an_in_q;
         trab_pkg::OFS_DIGITAL_PROBE_IN_SELECT: test_rdata[trab_pkg::W_DG_IN_SEL-1:0] = dg_in_q;
         trab_pkg::OFS_NONVOLATILE_BANK_ACCESS: test_rdata[trab_pkg::W_NV_BANK-1:0] = nv_q;
         trab_pkg::OFS_HOST_TAKEOVER_CONTROL: test_rdata[trab_pkg::W_TAKEOVER-1:0] = takeover_q;
         trab_pkg::OFS_SINGLE_WIRE_ERROR_LOW: test_rdata[trab_pkg::W_ERR_LOW-1:0] = err_low_q;
         trab_pkg::OFS_SINGLE_WIRE_ERROR_HIGH: test_rdata[trab_pkg::W_ERR_HIGH-1:0] = err_high_q;
         default: test_rdata = trab_pkg::RESET_BYTE;
      endcase
   end

   // access sequencer: test space answers in one cycle, memory waits for ack or refusal
   always_comb begin
      state_next = state_reg;
      ack_next = 1'b0;
      rdata_next = rdata_reg;
      case (state_reg)
         trab_pkg::TRAB_IDLE: begin
            if (test_wr | test_rd) begin
               ack_next = 1'b1;
               rdata_next = test_rd ? test_rdata : trab_pkg::RESET_BYTE;
            end else if (mem_start) begin
               state_next = trab_pkg::TRAB_MEM_WAIT;
            end
         end
         trab_pkg::TRAB_MEM_WAIT: begin
            if (refused) begin
               ack_next = 1'b1;
               rdata_next = trab_pkg::RESET_BYTE;
               state_next = trab_pkg::TRAB_IDLE;
            end else if (mem_ack) begin
               ack_next = 1'b1;
               rdata_next = mem_wr ? trab_pkg::RESET_BYTE : mem_rdata;
               state_next = trab_pkg::TRAB_IDLE;
            end
         end
         default: state_next = trab_pkg::TRAB_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= trab_pkg::TRAB_IDLE;
         ack_reg <= 1'b0;
         rdata_reg <= trab_pkg::RESET_BYTE;
      end else begin
         state_reg <= state_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   // outputs, each straight from a register flop
   assign sif_ack = ack_reg;
   assign sif_rdata = rdata_reg;
   assign mcu_reset_hold = takeover_q[trab_pkg::BIT_MCU_RESET];
   assign comm_buffer_byte = comm_buf_q;
   assign comm_data_valid = comm_rdy_q[trab_pkg::BIT_COMM_VALID];
   assign single_wire_error_low = err_low_q;
   assign single_wire_error_high = err_high_q;
   assign probe_in_p_enable = pin_act_q[trab_pkg::BIT_PROBE_IN_P];
   assign probe_out_n_enable = pin_act_q[trab_pkg::BIT_PROBE_OUT_N];
   assign probe_out_p_enable = pin_act_q[trab_pkg::BIT_PROBE_OUT_P];
   assign analog_probe_out_select = an_out_q;
   assign digital_probe_out_select = dg_out_q;
   assign analog_probe_in_select = an_in_q;
   assign digital_probe_in_select = dg_in_q;
   assign nonvolatile_bank_access = nv_q;
endmodule

//--- tb/trab_mem_model.sv
`timescale 1ns/1ps
// memory behind the bank, answers promptly or after a few idle cycles
module trab_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire logic [trab_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [trab_pkg::DATA_W-1:0] mem_wdata,
   output logic [trab_pkg::DATA_W-1:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] mem [256];
   logic pend;
   int cnt;
   // one access at a time; the read bus toggles when no answer is given
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
         mem_ack <= 1'b0;
         mem_rdata <= 8'h5a;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req) begin
            pend <= 1'b1;
            cnt <= slow ? 3 : 0;
            if (mem_wr) begin
               mem[mem_addr[7:0]] <= mem_wdata;
            end
         end else if (pend && cnt > 0) begin
            cnt <= cnt - 1;
         end else if (pend) begin
            pend <= 1'b0;
            mem_ack <= 1'b1;
            mem_rdata <= mem_wr ? 8'h00 : mem[mem_addr[7:0]];
         end
      end
   end
endmodule

//--- tb/trab_bank_props.sv
`timescale 1ns/1ps
// host port, memory port and output checks
module trab_bank_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sif_req,
   input wire logic sif_wr,
   input wire logic sif_test_space,
   input wire logic [trab_pkg::ADDR_W-1:0] sif_addr,
   input wire logic [trab_pkg::DATA_W-1:0] sif_wdata,
   input wire logic [trab_pkg::DATA_W-1:0] sif_rdata,
   input wire logic sif_ack,
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire logic [trab_pkg::DATA_W-1:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mcu_mem_enable,
   input wire logic mcu_reset_hold,
   input wire logic mcu_comm_load,
   input wire logic [trab_pkg::DATA_W-1:0] mcu_comm_byte,
   input wire logic [trab_pkg::DATA_W-1:0] comm_buffer_byte,
   input wire logic comm_data_valid,
   input wire logic [trab_pkg::W_ERR_LOW-1:0] single_wire_error_low_set,
   input wire logic [trab_pkg::W_ERR_LOW-1:0] single_wire_error_low,
   input wire logic probe_in_p_enable,
   input wire logic probe_out_n_enable,
   input wire logic probe_out_p_enable
);
   logic wait_reg;
   logic wait_next;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // tracks a memory-space access that still waits for its answer
   always_comb begin
      wait_next = wait_reg;
      if (sif_req && !sif_test_space && !wait_reg) begin
         wait_next = 1'b1;
      end else if (sif_ack) begin
         wait_next = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= wait_next;
      end
   end
   sequence s_mem_take;
      sif_req && !sif_test_space && !wait_reg;
   endsequence
   property p_test_ack;
      sif_req && sif_test_space && !wait_reg |=> sif_ack;
   endproperty
   a_test_ack: assert property (p_test_ack) else $error("no test ack");
   property p_refuse;
      s_mem_take and mcu_mem_enable |=> !mem_req ##1 (sif_ack && sif_rdata == 8'h00);
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad refusal");
   property p_grant;
      s_mem_take and !mcu_mem_enable |=> mem_req ##1 !mem_req;
   endproperty
   a_grant: assert property (p_grant) else $error("no mem pulse");
   property p_mcu_block;
      mcu_mem_enable |-> !mem_req;
   endproperty
   a_mcu_block: assert property (p_mcu_block) else $error("mem used by host");
   property p_mem_answer;
      wait_reg && mem_ack |=> sif_ack && sif_rdata == ($past(mem_wr) ? 8'h00 : $past(mem_rdata));
   endproperty
   a_mem_answer: assert property (p_mem_answer) else $error("bad mem answer");
   property p_probe;
      sif_req && sif_wr && sif_test_space && sif_addr[7:0] == 8'h03 |=>
         {probe_out_p_enable, probe_out_n_enable, probe_in_p_enable} == $past(sif_wdata[2:0]);
   endproperty
   a_probe: assert property (p_probe) else $error("bad probes");
   property p_take;
      sif_req && sif_wr && sif_test_space && sif_addr[7:0] == 8'h0e |=>
         mcu_reset_hold == $past(sif_wdata[1]) ##1 mcu_mem_enable == !$past(sif_wdata[0], 2);
   endproperty
   a_take: assert property (p_take) else $error("bad takeover");
   property p_err_set;
      single_wire_error_low_set != 8'h00 |=>
         (single_wire_error_low & $past(single_wire_error_low_set)) == $past(single_wire_error_low_set);
   endproperty
   a_err_set: assert property (p_err_set) else $error("error lost");
   property p_comm_load;
      mcu_comm_load |=> comm_data_valid && comm_buffer_byte == $past(mcu_comm_byte);
   endproperty
   a_comm_load: assert property (p_comm_load) else $error("bad load");
   property p_reset_vals;
      $rose(rst_n) |-> mcu_mem_enable && !mcu_reset_hold && !sif_ack && !comm_data_valid &&
         comm_buffer_byte == 8'h00 && single_wire_error_low == 8'h00 && !probe_in_p_enable;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
   c_refuse: cover property (s_mem_take and mcu_mem_enable);
   c_grant: cover property (s_mem_take and !mcu_mem_enable);
   c_load: cover property (mcu_comm_load);
endmodule
bind trab_bank trab_bank_props u_props (.*);

//--- tb/trab_bank_tb.sv
`timescale 1ns/1ps
module trab_bank_tb;
   logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
   logic sif_req = 1'b0, sif_wr = 1'b0, sif_test_space = 1'b0, mcu_comm_load = 1'b0;
   logic [15:0] sif_addr = 16'h0000, mem_addr, a;
   logic [7:0] sif_wdata = 8'h00, mcu_comm_byte = 8'h00, single_wire_error_low_set = 8'h00;
   logic [7:0] sif_rdata, mem_wdata, mem_rdata, comm_buffer_byte, single_wire_error_low;
   logic [7:0] rd, b, e, d;
   logic sif_ack, mem_req, mem_wr, mem_ack, mcu_mem_enable, mcu_reset_hold, comm_data_valid;
   logic [1:0] single_wire_error_high_set = 2'b00, single_wire_error_high;
   logic probe_in_p_enable, probe_out_n_enable, probe_out_p_enable;
   logic [5:0] analog_probe_out_select, analog_probe_in_select, nonvolatile_bank_access;
   logic [4:0] digital_probe_out_select;
   logic [3:0] digital_probe_in_select;
   int n_fail = 0, total_checks = 0, cyc = 0, nreq = 0, n0;
   logic [7:0] ofs [15] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0d,
      8'h14, 8'h15, 8'h00, 8'h0a, 8'h0e, 8'h1f, 8'hff};
   trab_bank dut (.*);
   trab_mem_model u_mem (.*);
   always #2.5 clk = ~clk;
   // counts memory pulses and cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (mem_req === 1'b1) nreq++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   // implemented bits per offset
   function automatic logic [7:0] msk(input logic [7:0] o);
      case (o)
         8'h03, 8'h09: msk = 8'h0f;
         8'h04, 8'h14: msk = 8'hff;
         8'h05: msk = 8'h01;
         8'h06, 8'h08, 8'h0d: msk = 8'h3f;
         8'h07: msk = 8'h1f;
         8'h0e, 8'h15: msk = 8'h03;
         default: msk = 8'h00;
      endcase
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one host access, bounded wait for the answer
   task automatic acc(input logic wr, input logic ts, input logic [15:0] ad,
         input logic [7:0] wd, output logic [7:0] r);
      int n = 0;
      @(posedge clk);
      sif_req <= 1'b1;
      sif_wr <= wr;
      sif_test_space <= ts;
      sif_addr <= ad;
      sif_wdata <= wd;
      @(posedge clk);
      sif_req <= 1'b0;
      #1;
      while (sif_ack !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("sif_ack", 8'h01, {7'h00, sif_ack});
      r = sif_rdata;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(29));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk("mcu_mem_enable", 8'h01, {7'h00, mcu_mem_enable});
      foreach (ofs[i]) begin
         acc(1'b0, 1'b1, {8'h00, ofs[i]}, 8'h00, rd);
         chk("reset value", 8'h00, rd);
         if (ofs[i] != 8'h0e) begin
            d = 8'($urandom);
            if (ofs[i] == 8'h03) d = d & 8'h07;
            acc(1'b1, 1'b1, {8'($urandom), ofs[i]}, d, rd);
            acc(1'b0, 1'b1, {8'h00, ofs[i]}, 8'h00, rd);
            chk("read back", d & msk(ofs[i]), rd);
         end
      end
      $display("test reset and read write done");
      for (int v = 0; v < 8; v++) begin
         acc(1'b1, 1'b1, 16'h0003, 8'(v), rd);
         chk("probe enables", 8'(v),
            {5'h00, probe_out_p_enable, probe_out_n_enable, probe_in_p_enable});
      end
      $display("test probe enables done");
      acc(1'b1, 1'b1, 16'h0003, 8'h08, rd);
      acc(1'b1, 1'b1, 16'h0003, 8'h00, rd);
      e = 8'($urandom) | 8'h01;
      @(posedge clk);
      single_wire_error_low_set <= e;
      single_wire_error_high_set <= 2'b11;
      @(posedge clk);
      single_wire_error_low_set <= 8'h00;
      single_wire_error_high_set <= 2'b00;
      repeat (5) @(posedge clk);
      #1;
      chk("error low kept", e, single_wire_error_low);
      chk("error high kept", 8'h03, {6'h00, single_wire_error_high});
      acc(1'b1, 1'b1, 16'h0003, 8'h08, rd);
      @(posedge clk);
      #1;
      chk("error low cleared", 8'h00, single_wire_error_low);
      chk("error high cleared", 8'h00, {6'h00, single_wire_error_high});
      acc(1'b1, 1'b1, 16'h0003, 8'h00, rd);
      $display("test error bits done");
      b = 8'($urandom);
      @(posedge clk);
      mcu_comm_load <= 1'b1;
      mcu_comm_byte <= b;
      @(posedge clk);
      mcu_comm_load <= 1'b0;
      mcu_comm_byte <= ~b;
      acc(1'b0, 1'b1, 16'h0004, 8'h00, rd);
      chk("comm buffer", b, rd);
      acc(1'b0, 1'b1, 16'h0005, 8'h00, rd);
      chk("comm ready", 8'h01, rd);
      acc(1'b1, 1'b1, 16'h0005, 8'h00, rd);
      acc(1'b0, 1'b1, 16'h0005, 8'h00, rd);
      chk("comm ready cleared", 8'h00, rd);
      $display("test comm buffer done");
      n0 = nreq;
      acc(1'b1, 1'b0, 16'($urandom), 8'($urandom), rd);
      chk("refused write", 8'h00, rd);
      acc(1'b0, 1'b0, 16'($urandom), 8'h00, rd);
      chk("refused read", 8'h00, rd);
      chk("refused mem pulses", 8'h00, 8'(nreq - n0));
      $display("test refusal done");
      acc(1'b1, 1'b1, 16'h000e, 8'h02, rd);
      chk("mcu_reset_hold", 8'h01, {7'h00, mcu_reset_hold});
      acc(1'b1, 1'b1, 16'h000e, 8'h03, rd);
      @(posedge clk);
      #1;
      chk("mcu blocked", 8'h00, {7'h00, mcu_mem_enable});
      n0 = nreq;
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         a = 16'($urandom);
         d = 8'($urandom);
         acc(1'b1, 1'b0, a, d, rd);
         chk("mem write answer", 8'h00, rd);
         acc(1'b0, 1'b0, a, 8'h00, rd);
         chk("mem read", d, rd);
      end
      chk("granted mem pulses", 8'h04, 8'(nreq - n0));
      acc(1'b0, 1'b1, 16'h0004, 8'h00, rd);
      chk("buffer while host owns", b, rd);
      acc(1'b1, 1'b1, 16'h000e, 8'h00, rd);
      @(posedge clk);
      #1;
      chk("mcu released", 8'h01, {7'h00, mcu_mem_enable});
      $display("test takeover done");
      wrap_up();
   end
endmodule
